/* File: rtl/twm_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes a power-of-two depth and a single clock.
`timescale 1ns/100ps
`default_nettype none
module twm_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    twm_strm_if.snk in_s,
    twm_strm_if.src out_s
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp_reg;
    logic [AW:0] rp_reg;
    logic push;
    logic pop;
    logic full;

    assign full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
    assign in_s.ready = !full;
    assign out_s.valid = (wp_reg != rp_reg);
    assign out_s.data = mem[rp_reg[AW-1:0]];
    assign push = in_s.valid && !full;
    assign pop = out_s.valid && out_s.ready;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
        end
    end

    // ********************************
    // Storage
    // ********************************
    for (genvar g = 0; g < D; g++) begin : g_ent
        always_ff @(posedge clk) begin
            if (push && (wp_reg[AW-1:0] == AW'(g))) begin
                mem[g] <= in_s.data;
            end
        end
    end
endmodule : twm_fifo
`default_nettype wire

/* File: rtl/twm_map.svh */
// Constants of the two-wire serial master: timing, bit positions, sizes.
// Assumes a 200 MHz core clock; included by the package, the master and the stream interface.
// Contract
// (R1) Serial clock selectable at 100 kHz, 400 kHz or 800 kHz.
// (R2) A 1 MHz serial clock setting is also offered.
// (R3) Sole master on the bus; no arbitration is performed.
// (R4) No wait states: master never stretches and ignores slave stretching; the code holds the clock low while a write byte is missing or the FIFO is full.
// (R5) Read-only transfer receives one to 16 bytes.
// (R6) Write-only transfer sends one to 16 bytes.
// (R7) Combined transfer: read up to 16 bytes, then write up to 16.
// (R8) Combined transfer: write up to 16 bytes, then read up to 16.
// (R9) Clock and data lines are only pulled low or released.
// (R10) Hardware runs the whole sequence once the transfer is configured.
// (R11) Master only, two signals, never answers as a slave.
// (R12) Standard start, stop, 7-bit address, direction bit and acknowledge.
// (R13) Repeated start plus address with new direction between phases.
// (R14) Missing acknowledge ends the transfer with stop and flags an error.
// (R15) Busy while a transfer runs; done once the final stop is driven; the code raises done a whole bit later, after the bus free time.
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH

// ********************************
// Timing
// ********************************
`define TWM_CLK_NS 5
`define TWM_PER_100K_NS 10000
`define TWM_PER_400K_NS 2500
`define TWM_PER_800K_NS 1250
`define TWM_PER_1M_NS 1000
// Quarter bit period in core cycles, rounded up so the rate never exceeds the setting
`define TWM_Q_CYC(ns) (((ns) / `TWM_CLK_NS + 3) / 4)

// ********************************
// Bit and byte layout
// ********************************
`define TWM_BYTE_W 8
`define TWM_FIFO_DEPTH 8
`define TWM_ACK_BIT 4'h8
`define TWM_Q_SAMPLE 2'h2
`define TWM_Q_LAST 2'h3
`define TWM_Q_FIRST 2'h0
`define TWM_DIV_W 9

`endif

/* File: rtl/twm_master.sv */
// Two-wire serial bus master: start, address, data, acknowledge, stop.
// Assumes external pull-ups on both lines and a single master on the bus.
`timescale 1ns/100ps
`default_nettype none
`include "twm_map.svh"
module twm_master (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire twm_pkg::twm_xfer_e xfer_type,
    input wire twm_pkg::twm_rate_e rate_sel,
    input wire logic [6:0] slave_addr,
    input wire logic [3:0] rd_len_m1,
    input wire logic [3:0] wr_len_m1,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic busy,
    output logic done,
    output logic nack_err,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_b,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_b
);
    import twm_pkg::*;

    twm_state_e state_reg;
    logic [1:0] q_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg;
    logic [3:0] rem_reg;
    logic [3:0] rem2_reg;
    logic cur_rd_reg;
    logic two_reg;
    logic second_reg;
    logic nack_reg;
    logic loaded_reg;
    logic [6:0] addr_reg;
    logic [`TWM_DIV_W-1:0] quart_reg;
    logic [`TWM_DIV_W-1:0] div_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] scl_sync_reg;
    logic tick;
    logic bit_end;
    logic sample;
    logic stall;
    logic tx;
    logic scl_low_next;
    logic sda_low_next;
    logic take;
    logic [`TWM_DIV_W-1:0] quart_next;

    twm_strm_if rx_in ();
    twm_strm_if rx_out ();

    twm_fifo #(.W(`TWM_BYTE_W), .D(`TWM_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_s(rx_in),
        .out_s(rx_out)
    );

    // Pin inputs cross two flops before use
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sda_sync_reg <= 2'h3;
            scl_sync_reg <= 2'h3;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
        end
    end

    // ********************************
    // Bit timing
    // ********************************
    always_comb begin
        case (rate_sel)
            TWM_R100K: quart_next = `TWM_DIV_W'(`TWM_Q_CYC(`TWM_PER_100K_NS)); // R1
            TWM_R400K: quart_next = `TWM_DIV_W'(`TWM_Q_CYC(`TWM_PER_400K_NS)); // R1
            TWM_R800K: quart_next = `TWM_DIV_W'(`TWM_Q_CYC(`TWM_PER_800K_NS)); // R1
            default: quart_next = `TWM_DIV_W'(`TWM_Q_CYC(`TWM_PER_1M_NS)); // R2
        endcase
    end

    assign tx = (state_reg == TWM_ADDR) || !cur_rd_reg;
    // Master holds the clock low while it waits for data or FIFO room
    assign stall = (state_reg == TWM_DATA) && (bit_reg == 4'h0) && (q_reg == `TWM_Q_FIRST)
        && (cur_rd_reg ? !rx_in.ready : !loaded_reg);
    // Slave clock stretching is not watched: the divider free-runs
    assign tick = (state_reg != TWM_IDLE) && !stall && (div_reg == quart_reg - 1'b1); // R4
    assign bit_end = tick && (q_reg == `TWM_Q_LAST);
    assign sample = tick && (q_reg == `TWM_Q_SAMPLE);
    assign take = wr_valid && wr_ready;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_reg <= '0;
        end else if (!tick && (state_reg != TWM_IDLE) && !stall) begin
            div_reg <= div_reg + 1'b1;
        end else begin
            div_reg <= '0;
        end
    end

    // ********************************
    // Sequencer
    // ********************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= TWM_IDLE;
            q_reg <= `TWM_Q_FIRST;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            rem_reg <= 4'h0;
            rem2_reg <= 4'h0;
            cur_rd_reg <= 1'b0;
            two_reg <= 1'b0;
            second_reg <= 1'b0;
            nack_reg <= 1'b0;
            addr_reg <= 7'h00;
            quart_reg <= `TWM_DIV_W'(`TWM_Q_CYC(`TWM_PER_100K_NS));
        end else begin
            if (tick) begin
                q_reg <= q_reg + 1'b1;
            end
            case (state_reg)
                TWM_IDLE: begin
                    if (go) begin // R3 R10
                        state_reg <= TWM_START;
                        q_reg <= `TWM_Q_FIRST;
                        addr_reg <= slave_addr;
                        quart_reg <= quart_next;
                        cur_rd_reg <= (xfer_type == TWM_READ) || (xfer_type == TWM_RD_WR);
                        two_reg <= xfer_type[1]; // R7 R8
                        second_reg <= 1'b0;
                        nack_reg <= 1'b0;
                        rem_reg <= (xfer_type == TWM_READ || xfer_type == TWM_RD_WR)
                            ? rd_len_m1 : wr_len_m1; // R5 R6
                        rem2_reg <= (xfer_type == TWM_RD_WR) ? wr_len_m1 : rd_len_m1;
                    end
                end
                TWM_START: begin
                    if (bit_end) begin // R12
                        state_reg <= TWM_ADDR;
                        bit_reg <= 4'h0;
                        shift_reg <= {addr_reg, cur_rd_reg};
                    end
                end
                TWM_ADDR, TWM_DATA: begin
                    if (take) begin
                        shift_reg <= wr_data;
                    end
                    if (sample && (bit_reg == `TWM_ACK_BIT) && tx && sda_sync_reg[1]) begin
                        nack_reg <= 1'b1; // R14
                    end
                    if (sample && (bit_reg != `TWM_ACK_BIT) && !tx) begin
                        shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
                    end
                    if (bit_end) begin
                        if (bit_reg != `TWM_ACK_BIT) begin
                            bit_reg <= bit_reg + 1'b1;
                            if (tx) begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                            end
                        end else begin
                            bit_reg <= 4'h0;
                            if (nack_reg) begin
                                state_reg <= TWM_STOP; // R14
                            end else if (state_reg == TWM_ADDR) begin
                                state_reg <= TWM_DATA;
                            end else if (rem_reg != 4'h0) begin
                                rem_reg <= rem_reg - 1'b1;
                            end else if (two_reg && !second_reg) begin
                                state_reg <= TWM_START; // R13
                                second_reg <= 1'b1;
                                cur_rd_reg <= !cur_rd_reg;
                                rem_reg <= rem2_reg;
                            end else begin
                                state_reg <= TWM_STOP;
                            end
                        end
                    end
                end
                TWM_STOP: begin
                    if (bit_end) begin
                        state_reg <= TWM_FREE;
                    end
                end
                default: begin
                    // Bus free time of a whole bit before the next start
                    if (bit_end) begin
                        state_reg <= TWM_IDLE;
                    end
                end
            endcase
        end
    end

    // Write bytes are fetched one per data byte; a late byte stalls the clock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ready <= 1'b0;
            loaded_reg <= 1'b0;
        end else begin
            wr_ready <= (state_reg == TWM_DATA) && !cur_rd_reg && (bit_reg == 4'h0)
                && !loaded_reg && !take; // R6
            if (take) begin
                loaded_reg <= 1'b1;
            end else if (bit_end && (bit_reg == `TWM_ACK_BIT)) begin
                loaded_reg <= 1'b0;
            end
        end
    end

    // Received bytes enter the FIFO when their acknowledge bit ends
    assign rx_in.valid = (state_reg == TWM_DATA) && cur_rd_reg && bit_end
        && (bit_reg == `TWM_ACK_BIT); // R5 R7 R8
    assign rx_in.data = shift_reg;
    assign rx_out.ready = rd_ready;
    assign rd_data = rx_out.data;
    assign rd_valid = rx_out.valid;

    // ********************************
    // Line drive
    // ********************************
    always_comb begin
        scl_low_next = 1'b0;
        sda_low_next = 1'b0;
        case (state_reg)
            TWM_START: begin
                scl_low_next = second_reg && (q_reg == `TWM_Q_FIRST);
                sda_low_next = q_reg[1]; // R12 R13
            end
            TWM_ADDR, TWM_DATA: begin
                scl_low_next = (q_reg == `TWM_Q_FIRST) || (q_reg == `TWM_Q_LAST);
                if (bit_reg != `TWM_ACK_BIT) begin
                    sda_low_next = tx && !shift_reg[7];
                end else begin
                    sda_low_next = !tx && (rem_reg != 4'h0); // R12
                end
            end
            TWM_STOP: begin
                scl_low_next = !q_reg[1];
                sda_low_next = (q_reg != `TWM_Q_LAST); // R12
            end
            default: begin
                scl_low_next = 1'b0;
                sda_low_next = 1'b0;
            end
        endcase
    end

    // Open drain: the output value is always low, only the enable moves
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_b <= 1'b1;
            sda_oe_b <= 1'b1;
        end else begin
            scl_o <= 1'b0; // R9 R11
            sda_o <= 1'b0; // R9
            scl_oe_b <= !scl_low_next;
            sda_oe_b <= !sda_low_next;
        end
    end

    // ********************************
    // Status
    // ********************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy <= 1'b0;
            done <= 1'b0;
            nack_err <= 1'b0;
        end else begin
            busy <= (state_reg != TWM_IDLE) && !((state_reg == TWM_FREE) && bit_end); // R15
            done <= (state_reg == TWM_FREE) && bit_end; // R15
            if ((state_reg == TWM_FREE) && bit_end) begin
                nack_err <= nack_reg; // R14
            end
        end
    end

    // ********************************
    // Checks
    // ********************************
    logic [10:0] hi_cnt;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hi_cnt <= 11'h000;
        end else begin
            hi_cnt <= scl_oe_b ? hi_cnt + 1'b1 : 11'h000;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_rate;
        $fell(scl_oe_b) && (state_reg == TWM_DATA) && (q_reg == `TWM_Q_LAST)
            |-> hi_cnt == {1'b0, quart_reg, 1'b0};
    endproperty
    a_rate: assert property (p_rate) else $error("clock high time off"); // R1
    property p_fast;
        (state_reg == TWM_START) && (quart_reg == 9'h032) |-> ##1 (quart_reg == 9'h032);
    endproperty
    a_fast: assert property (p_fast) else $error("rate changed mid transfer"); // R2
    property p_od;
        scl_o == 1'b0 && sda_o == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("line driven high"); // R9
    property p_go;
        (state_reg == TWM_IDLE) && go |=> ##1 busy && (state_reg == TWM_START);
    endproperty
    a_go: assert property (p_go) else $error("transfer not launched"); // R10
    property p_sda_hi;
        $fell(sda_oe_b) && $past(scl_oe_b) && scl_oe_b |-> $past(state_reg, 2) == TWM_START;
    endproperty
    a_sda_hi: assert property (p_sda_hi) else $error("data fell with clock high"); // R12
    property p_restart;
        $rose(second_reg) |-> (state_reg == TWM_START) && $changed(cur_rd_reg);
    endproperty
    a_restart: assert property (p_restart) else $error("bad repeated start"); // R13
    property p_nack;
        $rose(nack_reg) |-> ##[1:600] (state_reg == TWM_STOP);
    endproperty
    a_nack: assert property (p_nack) else $error("no stop after nack"); // R14
    property p_done;
        done |-> !busy && $past(state_reg) == TWM_FREE;
    endproperty
    a_done: assert property (p_done) else $error("done while busy"); // R15
    property p_push;
        rx_in.valid |-> cur_rd_reg && rx_in.ready;
    endproperty
    a_push: assert property (p_push) else $error("push while writing or full"); // R5
    property p_take;
        take |-> (state_reg == TWM_DATA) && !cur_rd_reg;
    endproperty
    a_take: assert property (p_take) else $error("write byte taken out of phase"); // R6
    property p_stretch;
        tick && (q_reg == `TWM_Q_SAMPLE) |-> ##1 scl_oe_b;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not released"); // R4

    c_ok: cover property (done && !nack_err);
    c_err: cover property (done && nack_err);
    c_combo: cover property ($rose(second_reg));
    c_stall: cover property (stall && cur_rd_reg && scl_sync_reg[1] == 1'b0);
endmodule : twm_master
`default_nettype wire

/* File: rtl/twm_pkg.sv */
// Types shared by the two-wire serial master modules.
// Assumes twm_map.svh is on the include path.
`include "twm_map.svh"
package twm_pkg;
    typedef enum logic [1:0] {
        TWM_READ = 2'h0,
        TWM_WRITE = 2'h1,
        TWM_RD_WR = 2'h2,
        TWM_WR_RD = 2'h3
    } twm_xfer_e;

    typedef enum logic [1:0] {
        TWM_R100K = 2'h0,
        TWM_R400K = 2'h1,
        TWM_R800K = 2'h2,
        TWM_R1M = 2'h3
    } twm_rate_e;

    // Gray codes along idle-start-address-data-stop-free
    typedef enum logic [2:0] {
        TWM_IDLE = 3'h0,
        TWM_START = 3'h1,
        TWM_ADDR = 3'h3,
        TWM_DATA = 3'h2,
        TWM_STOP = 3'h6,
        TWM_FREE = 3'h7
    } twm_state_e;
endpackage : twm_pkg

/* File: rtl/twm_strm_if.sv */
// Byte stream carrier between the master engine and its receive FIFO.
// Assumes one clock domain on both ends.
`timescale 1ns/100ps
`default_nettype none
`include "twm_map.svh"
interface twm_strm_if;
    logic [`TWM_BYTE_W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : twm_strm_if
`default_nettype wire

/* File: sim/twm_slv.sv */
// Behavioural slave device on the far side of the two-wire master.
// Assumes the bench resolves both lines as wired-AND with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module twm_slv (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_addr,
    input wire logic [4:0] nack_at,
    output logic sda_pull
);
    // ****************************************
    // Capture records for the bench
    // ****************************************
    logic [7:0] aq[$];
    logic [7:0] wq[$];
    int n_stop;
    int n_sent;
    logic [7:0] a;
    int ev;

    // ****************************************
    // Bit level; ev 0 byte, 1 start, 2 stop
    // ****************************************
    task automatic get_byte(output logic [7:0] v, output int e);
        logic b;
        e = 0;
        for (int i = 7; i >= 0; i--) begin
            @(posedge scl);
            b = sda;
            @(negedge scl or sda);
            if (scl === 1'b1) begin
                e = sda ? 2 : 1;
                return;
            end
            v[i] = b;
        end
    endtask : get_byte

    // Changes data only while the clock is low, never holds the clock
    task automatic ack(input logic k);
        sda_pull = k;
        @(posedge scl);
        @(negedge scl);
        sda_pull = 1'b0;
    endtask : ack

    task automatic wait_cond(output int e);
        do @(sda); while (scl !== 1'b1);
        e = sda ? 2 : 1;
    endtask : wait_cond

    task automatic send_byte(input logic [7:0] v, output logic m_ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~v[i];
            @(posedge scl);
            @(negedge scl);
        end
        sda_pull = 1'b0;
        @(posedge scl);
        m_ack = ~sda;
        @(negedge scl);
    endtask : send_byte

    task automatic read_phase(output int e);
        logic m_ack;
        int k;
        k = 0;
        m_ack = 1'b1;
        while (m_ack) begin
            send_byte(8'hA0 + 8'(k), m_ack);
            k++;
            n_sent++;
        end
        wait_cond(e);
    endtask : read_phase

    task automatic write_phase(output int e);
        logic [7:0] v;
        int k;
        k = 0;
        e = 0;
        while (e == 0) begin
            get_byte(v, e);
            if (e == 0) begin
                k++;
                wq.push_back(v);
                ack(k != nack_at);
                if (k == nack_at) begin
                    wait_cond(e);
                end
            end
        end
    endtask : write_phase

    // Answers only; never starts a frame of its own
    initial begin
        sda_pull = 1'b0;
        n_stop = 0;
        n_sent = 0;
        forever begin
            do @(negedge sda); while (scl !== 1'b1);
            ev = 1;
            while (ev == 1) begin
                get_byte(a, ev);
                aq.push_back(a);
                ack(!nack_addr);
                if (nack_addr) begin
                    wait_cond(ev);
                end else if (a[0]) begin
                    read_phase(ev);
                end else begin
                    write_phase(ev);
                end
            end
            n_stop++;
        end
    end
endmodule : twm_slv
`default_nettype wire

/* File: sim/two_wire_serial_master_tb.sv */
// Self-checking bench for the two-wire master against a slave model.
// Assumes 200 MHz core clock and pull-ups on both lines.
`timescale 1ns/100ps
`default_nettype none
module two_wire_serial_master_tb;
    import twm_pkg::*;
    logic clk, rst_b, go, wr_valid, rd_ready, rd_en, nack_addr, drv_hi, scl_q;
    twm_xfer_e xfer_type;
    twm_rate_e rate_sel;
    logic [6:0] slave_addr;
    logic [3:0] rd_len_m1, wr_len_m1;
    logic [7:0] wr_data, rd_data;
    logic [4:0] nack_at;
    logic wr_ready, rd_valid, busy, done, nack_err;
    logic scl_o, scl_oe_b, sda_o, sda_oe_b, sda_pull;
    wire logic scl_w;
    wire logic sda_w;
    logic [7:0] wsrc[$];
    logic [7:0] rq[$];
    int n_fail, n_compared, n_rise, cyc, per;
    // Wired-AND: released lines sit at the pull-up level
    assign scl_w = scl_oe_b;
    assign sda_w = sda_oe_b & ~sda_pull;

    twm_master twm_master_inst (.clk(clk), .rst_b(rst_b), .go(go), .xfer_type(xfer_type),
        .rate_sel(rate_sel), .slave_addr(slave_addr), .rd_len_m1(rd_len_m1),
        .wr_len_m1(wr_len_m1), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .busy(busy),
        .done(done), .nack_err(nack_err), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_b(scl_oe_b), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_b(sda_oe_b));
    twm_slv twm_slv_inst (.scl(scl_w), .sda(sda_w), .nack_addr(nack_addr),
        .nack_at(nack_at), .sda_pull(sda_pull));

    // ****************************************
    // Clock, stream drivers, monitors
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) begin
        wr_valid <= (wsrc.size() != 0);
        wr_data <= (wsrc.size() != 0) ? wsrc[0] : 8'h00;
        rd_ready <= rd_en;
    end
    always @(posedge clk) begin
        if (wr_valid && wr_ready === 1'b1) wsrc.pop_front();
        if (rd_valid === 1'b1 && rd_ready) rq.push_back(rd_data);
        if (rst_b && (scl_o !== 1'b0 || sda_o !== 1'b0)) drv_hi <= 1'b1;
    end
    // Period between the first two clock rises of a transfer
    always @(posedge clk) begin
        scl_q <= scl_w;
        cyc <= cyc + 1;
        if (go && !busy) begin
            n_rise <= 0;
        end else if (scl_w && !scl_q) begin
            n_rise <= n_rise + 1;
            cyc <= 0;
            if (n_rise == 1) per <= cyc + 1;
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    function automatic int q4(input int ns);
        return 4 * ((ns / 5 + 3) / 4);
    endfunction : q4
    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic start_xfer(input twm_xfer_e t, input twm_rate_e r, input logic [6:0] a,
        input logic [3:0] rl, input logic [3:0] wl);
        twm_slv_inst.aq.delete();
        twm_slv_inst.wq.delete();
        twm_slv_inst.n_stop = 0;
        twm_slv_inst.n_sent = 0;
        rq.delete();
        @(negedge clk);
        xfer_type = t;
        rate_sel = r;
        slave_addr = a;
        rd_len_m1 = rl;
        wr_len_m1 = wl;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        @(negedge clk);
        cmp_bit(busy, 1'b1);
    endtask : start_xfer
    task automatic end_xfer(input logic en);
        for (int i = 0; i < 60000; i++) begin
            @(negedge clk);
            if (done === 1'b1) break;
        end
        cmp_bit(done, 1'b1);
        cmp_bit(busy, 1'b0);
        cmp_bit(nack_err, en);
    endtask : end_xfer
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_addr_nack();
        nack_addr = 1'b1;
        start_xfer(TWM_WRITE, TWM_R100K, 7'h2A, 4'h0, 4'h0);
        end_xfer(1'b1);
        nack_addr = 1'b0;
        cmp_val(twm_slv_inst.aq[0], 8'h54);
        cmp_val(twm_slv_inst.wq.size(), 0);
        cmp_val(twm_slv_inst.n_stop, 1);
        cmp_val(per, q4(10000));
        $display("test addr_nack done");
    endtask : t_addr_nack
    task automatic t_write();
        wsrc = '{8'h3C, 8'hC5};
        start_xfer(TWM_WRITE, TWM_R400K, 7'h50, 4'h0, 4'h1);
        repeat (20) @(negedge clk);
        xfer_type = TWM_READ;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        end_xfer(1'b0);
        cmp_val(twm_slv_inst.aq.size(), 1);
        cmp_val(twm_slv_inst.aq[0], 8'hA0);
        cmp_val(twm_slv_inst.wq.size(), 2);
        cmp_val(twm_slv_inst.wq[0], 8'h3C);
        cmp_val(twm_slv_inst.wq[1], 8'hC5);
        cmp_val(per, q4(2500));
        $display("test write done");
    endtask : t_write
    task automatic t_read_fill();
        rd_en = 1'b0;
        start_xfer(TWM_READ, TWM_R1M, 7'h33, 4'hF, 4'h0);
        for (int i = 0; i < 40000 && twm_slv_inst.n_sent < 8; i++) @(negedge clk);
        // Two byte times with a full buffer: the bus must stay held
        repeat (3600) @(negedge clk);
        cmp_val(twm_slv_inst.n_sent, 8);
        cmp_bit(rd_valid, 1'b1);
        rd_en = 1'b1;
        end_xfer(1'b0);
        cmp_bit(rd_valid, 1'b0);
        cmp_val(rq.size(), 16);
        for (int i = 0; i < 16; i++) cmp_val(rq[i], 8'hA0 + 8'(i));
        cmp_val(twm_slv_inst.aq[0], 8'h67);
        cmp_val(per, q4(1000));
        $display("test read_fill done");
    endtask : t_read_fill
    task automatic t_wr_rd();
        wsrc = '{8'h96};
        start_xfer(TWM_WR_RD, TWM_R800K, 7'h0F, 4'h1, 4'h0);
        end_xfer(1'b0);
        cmp_val(twm_slv_inst.aq[0], 8'h1E);
        cmp_val(twm_slv_inst.aq[1], 8'h1F);
        cmp_val(twm_slv_inst.n_stop, 1);
        cmp_val(twm_slv_inst.wq[0], 8'h96);
        cmp_val(rq[0], 8'hA0);
        cmp_val(rq[1], 8'hA1);
        cmp_val(per, q4(1250));
        $display("test wr_rd done");
    endtask : t_wr_rd
    task automatic t_rd_wr_nack();
        nack_at = 5'h02;
        wsrc = '{8'h5A, 8'hE1};
        start_xfer(TWM_RD_WR, TWM_R1M, 7'h71, 4'h0, 4'h1);
        end_xfer(1'b1);
        nack_at = 5'h00;
        cmp_val(twm_slv_inst.aq[0], 8'hE3);
        cmp_val(twm_slv_inst.aq[1], 8'hE2);
        cmp_val(rq[0], 8'hA0);
        cmp_val(twm_slv_inst.wq[1], 8'hE1);
        cmp_val(twm_slv_inst.n_stop, 1);
        cmp_bit(drv_hi, 1'b0);
        $display("test rd_wr_nack done");
    endtask : t_rd_wr_nack

    initial begin
        {rst_b, go, wr_valid, rd_ready, nack_addr, drv_hi, scl_q} = 7'h00;
        {slave_addr, rd_len_m1, wr_len_m1, wr_data, nack_at} = 28'h0000000;
        xfer_type = TWM_READ;
        rate_sel = TWM_R1M;
        rd_en = 1'b1;
        {n_fail, n_compared} = 64'h0;
        {n_rise, cyc, per} = 96'h0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        cmp_bit(sda_oe_b, 1'b1);
        t_addr_nack();
        t_write();
        t_read_fill();
        t_wr_rd();
        t_rd_wr_nack();
        complete_run();
    end
    // About 96k cycles needed; limit leaves margin
    initial begin
        #700000;
        n_fail++;
        complete_run();
    end
endmodule : two_wire_serial_master_tb
`default_nettype wire
